// *** rtl/insn_decoder.sv ***
// Instruction decoder with APB register access: software writes a 14-bit
// word plus skip context, reads back the decoded class and cycle cost.
// Assumes an APB master on pclk; instruction cycle = 4 oscillator periods.
//
// Notes on behaviour
// - 001100: rotate right through carry, C only
// - 111011: file minus acc minus borrow, C DC Z
// - 000110: xor acc with file, Z only
// - 001011: decrement, skip on zero, 1(2)
// - 001111: increment, skip on zero, 1(2)
// - 0110bb: bit test, skip if clear
// - 0111bb: bit test, skip if set
// - 111000: or literal into acc, Z only
// - 1100011: load page latch, no flags
// - 111100: literal minus acc, C DC Z
// - Word 000b: branch by acc, two cycles
// - Word 000a: call by acc, two cycles
// - Word 0009: interrupt return, two cycles
// - 110100: return with literal, two cycles
// - Word 0064: watchdog restart, TO PD flags
// - Word 0062: acc into option register
// - Word 0001: software reset, one cycle
// - Word 0063: standby, TO PD flags
// - 1100010n: add literal to pointer, one cycle
// - 1111110n: indexed indirect read, Z flag
// - PC change or true test: two cycles
// - Indirect access, pointer MSB set: extra cycle
// - Instruction words are fourteen bits wide
// - Dest 0 to acc, 1 to file
// - Instruction cycle is four oscillator periods
`timescale 1ns/1ps
`default_nettype none
module insn_decoder
  import insn_decoder_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [4:0]  op_class,
  output logic             dest_file,
  output logic      [4:0]  flag_mask,
  output logic      [1:0]  cycles,
  output logic             decode_valid
);

  logic              en_r;
  logic [WORD_W-1:0] word_r;
  logic [1:0]        ctx_r;
  logic [1:0]        ptr_msb_r;
  logic [7:0]        count_r;
  logic              load_r;

  op_class_type cls_nxt;
  logic         dest_nxt;
  logic [4:0]   flags_nxt;
  logic [1:0]   cyc_nxt;
  logic         skip_nxt;
  logic         ind_nxt;

  wire logic acc_setup = psel && !penable;
  wire logic acc_done  = psel && penable;
  wire logic wr_done   = acc_done && pwrite;
  wire logic mapped    = (paddr == OFS_CTRL) || (paddr == OFS_WORD) ||
                         (paddr == OFS_CONTEXT) || (paddr == OFS_RESULT) ||
                         (paddr == OFS_PTRS);

  // Ready is asserted one cycle after setup: every access takes two edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= acc_setup;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= acc_setup && !mapped;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_r      <= EN_RST;
      word_r    <= WORD_RST;
      ctx_r     <= 2'h0;
      ptr_msb_r <= 2'h0;
    end
    else if (wr_done && pready)
    begin
      unique case (paddr)
        OFS_CTRL:    en_r      <= pwdata[CTRL_EN_BIT];
        OFS_WORD:    word_r    <= pwdata[WORD_W-1:0];
        OFS_CONTEXT: ctx_r     <= pwdata[1:0];
        OFS_PTRS:    ptr_msb_r <= pwdata[1:0];
        default:     ;
      endcase
    end
  end

  // Word write while enabled (en_r set) launches a decode on the next edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      load_r <= 1'b0;
    else
      load_r <= wr_done && pready && (paddr == OFS_WORD) && en_r;
  end

  always_comb
  begin
    logic [6:0] faddr;
    logic       ind_hi;
    faddr     = word_r[6:0];
    cls_nxt   = nop_op;
    dest_nxt  = 1'b0;
    flags_nxt = FLG_NONE;
    cyc_nxt   = CYC_ONE;
    skip_nxt  = 1'b0;
    ind_nxt   = 1'b0;
    ind_hi    = (faddr == ADDR_IND0) ? ptr_msb_r[PTR0_MSB_BIT] :
                ptr_msb_r[PTR1_MSB_BIT];
    if (word_r == W_BRANCH_ACC)
    begin
      cls_nxt = branch_by_acc_op;
      cyc_nxt = CYC_TWO;
    end
    else if (word_r == W_CALL_ACC)
    begin
      cls_nxt = call_by_acc_op;
      cyc_nxt = CYC_TWO;
    end
    else if (word_r == W_INT_RET)
    begin
      cls_nxt = interrupt_return_op;
      cyc_nxt = CYC_TWO;
    end
    else if (word_r == W_WDT)
    begin
      cls_nxt   = watchdog_restart_op;
      flags_nxt = FLG_TOPD;
    end
    else if (word_r == W_OPTION)
      cls_nxt = option_load_op;
    else if (word_r == W_SWRESET)
      cls_nxt = software_reset_op;
    else if (word_r == W_STANDBY)
    begin
      cls_nxt   = standby_op;
      flags_nxt = FLG_TOPD;
    end
    else
    begin
      unique case (word_r[13:8])
        TOP_RRF:
        begin
          cls_nxt   = rotate_right_carry_op;
          flags_nxt = FLG_C;
          dest_nxt  = word_r[7];
          ind_nxt   = 1'b1;
        end
        TOP_SUBB:
        begin
          cls_nxt   = subtract_borrow_op;
          flags_nxt = FLG_CDZ;
          dest_nxt  = word_r[7];
          ind_nxt   = 1'b1;
        end
        TOP_XOR:
        begin
          cls_nxt   = xor_acc_file_op;
          flags_nxt = FLG_Z;
          dest_nxt  = word_r[7];
          ind_nxt   = 1'b1;
        end
        TOP_DECS:
        begin
          cls_nxt  = decrement_skip_zero_op;
          dest_nxt = word_r[7];
          skip_nxt = ctx_r[CTX_ZERO_BIT];
          ind_nxt  = 1'b1;
        end
        TOP_INCS:
        begin
          cls_nxt  = increment_skip_zero_op;
          dest_nxt = word_r[7];
          skip_nxt = ctx_r[CTX_ZERO_BIT];
          ind_nxt  = 1'b1;
        end
        TOP_IOR:
        begin
          cls_nxt   = or_literal_op;
          flags_nxt = FLG_Z;
        end
        TOP_SUBL:
        begin
          cls_nxt   = literal_minus_acc_op;
          flags_nxt = FLG_CDZ;
        end
        TOP_RETL:
        begin
          cls_nxt = return_literal_op;
          cyc_nxt = CYC_TWO;
        end
        TOP_LIT1:
        begin
          if (word_r[7])
            cls_nxt = load_page_latch_op;
          else
            cls_nxt = pointer_add_op;
        end
        TOP_IDX:
        begin
          if (!word_r[7])
          begin
            cls_nxt   = indirect_read_op;
            flags_nxt = FLG_Z;
            ind_hi    = word_r[6] ? ptr_msb_r[PTR1_MSB_BIT] : ptr_msb_r[PTR0_MSB_BIT];
            if (ind_hi)
              cyc_nxt = CYC_TWO;
          end
        end
        default:
        begin
          // Bit tests match the top four bits, each shared by four bit-index codes
          if (word_r[13:10] == TOP_BTC)
          begin
            cls_nxt  = bit_test_skip_clear_op;
            skip_nxt = !ctx_r[CTX_BIT_BIT];
            ind_nxt  = 1'b1;
          end
          else if (word_r[13:10] == TOP_BTS)
          begin
            cls_nxt  = bit_test_skip_set_op;
            skip_nxt = ctx_r[CTX_BIT_BIT];
            ind_nxt  = 1'b1;
          end
        end
      endcase
      // Anything unmatched stays a one-cycle nop
    end
    if (skip_nxt)
      cyc_nxt = CYC_TWO;
    // Indirect operand through a high pointer costs one more cycle
    if (ind_nxt && (faddr == ADDR_IND0 || faddr == ADDR_IND1) && ind_hi)
      cyc_nxt = cyc_nxt + CYC_ONE;
  end

  // Outputs settle together on the decode edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_class     <= nop_op;
      dest_file    <= 1'b0;
      flag_mask    <= FLG_NONE;
      cycles       <= CYC_ONE;
      decode_valid <= 1'b0;
    end
    else
    begin
      decode_valid <= load_r;
      if (load_r)
      begin
        op_class  <= cls_nxt;
        dest_file <= dest_nxt;
        flag_mask <= flags_nxt;
        cycles    <= cyc_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= 8'h00;
    else if (load_r)
      count_r <= count_r + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (acc_setup && !pwrite)
    begin
      unique case (paddr)
        OFS_CTRL:    prdata <= {31'h0, en_r};
        OFS_WORD:    prdata <= {18'h0, word_r};
        OFS_CONTEXT: prdata <= {30'h0, ctx_r};
        OFS_PTRS:    prdata <= {30'h0, ptr_msb_r};
        OFS_RESULT:  prdata <= {count_r, 2'h0, cycles, 3'h0, flag_mask,
                                3'h0, dest_file, 3'h0, op_class};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Instruction cycle length is a timing figure only; no oscillator here
  localparam int unsigned OSC_CHECK = OSC_PER_CYCLE;

  a_two_cycle_ctl: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r == W_BRANCH_ACC |=> cycles == CYC_TWO && op_class == branch_by_acc_op)
    else $error("branch by acc not two cycles");
  a_call_acc: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r == W_CALL_ACC |=> cycles == CYC_TWO)
    else $error("call by acc cycles wrong");
  a_rrf_flags: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:8] == TOP_RRF |=> flag_mask == FLG_C && dest_file == $past(word_r[7]))
    else $error("rotate flags or dest wrong");
  a_subb_flags: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:8] == TOP_SUBB |=> flag_mask == FLG_CDZ)
    else $error("subtract borrow flags wrong");
  a_skip_taken: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:8] == TOP_DECS && ctx_r[CTX_ZERO_BIT] && word_r[6:1] != 6'h00
    |=> cycles == CYC_TWO)
    else $error("taken skip not two cycles");
  a_btc_skip: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:10] == TOP_BTC && !ctx_r[CTX_BIT_BIT] && word_r[6:1] != 6'h00
    |=> cycles == CYC_TWO)
    else $error("bit clear skip wrong");
  a_wdt_flags: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r == W_WDT |=> flag_mask == FLG_TOPD && cycles == CYC_ONE)
    else $error("watchdog restart decode wrong");
  a_valid_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    decode_valid |=> !decode_valid)
    else $error("decode valid longer than one cycle");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("ready not given after setup");
  a_xor_zero_only: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:8] == TOP_XOR |=> flag_mask == FLG_Z && op_class == xor_acc_file_op)
    else $error("xor flags or class wrong");
  a_or_literal: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:8] == TOP_IOR |=> flag_mask == FLG_Z && cycles == CYC_ONE)
    else $error("or literal decode wrong");
  a_page_latch: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:7] == {TOP_LIT1, 1'b1}
    |=> flag_mask == FLG_NONE && op_class == load_page_latch_op)
    else $error("page latch load decode wrong");
  a_lit_minus_acc: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:8] == TOP_SUBL |=> flag_mask == FLG_CDZ)
    else $error("literal minus acc flags wrong");
  a_int_return: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r == W_INT_RET |=> cycles == CYC_TWO && op_class == interrupt_return_op)
    else $error("interrupt return decode wrong");
  a_return_literal: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:8] == TOP_RETL |=> cycles == CYC_TWO && op_class == return_literal_op)
    else $error("return with literal decode wrong");
  a_standby_flags: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r == W_STANDBY |=> flag_mask == FLG_TOPD && op_class == standby_op)
    else $error("standby decode wrong");
  a_indirect_extra: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:7] == {TOP_IDX, 1'b0} && ptr_msb_r[word_r[6]] |=> cycles == CYC_TWO)
    else $error("indirect read through high pointer not two cycles");
  a_bts_skip: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:10] == TOP_BTS && ctx_r[CTX_BIT_BIT] && word_r[6:1] != 6'h00
    |=> cycles == CYC_TWO)
    else $error("bit set skip wrong");
  a_incs_skip: assert property (@(posedge pclk) disable iff (!presetn)
    load_r && word_r[13:8] == TOP_INCS && ctx_r[CTX_ZERO_BIT] && word_r[6:1] != 6'h00
    |=> cycles == CYC_TWO)
    else $error("increment skip not two cycles");

  c_skip: cover property (@(posedge pclk) decode_valid && cycles == CYC_TWO);
  c_three: cover property (@(posedge pclk) decode_valid && cycles == 2'h3);
  c_nop: cover property (@(posedge pclk) decode_valid && op_class == nop_op);
  c_ind_read: cover property (@(posedge pclk) decode_valid && op_class == indirect_read_op);

endmodule
`default_nettype wire

// *** rtl/insn_decoder_pkg.sv ***
// Package for the 14-bit instruction decoder: opcode patterns, classes,
// flag masks, cycle counts and register offsets.
// Assumes one 100 MHz bus clock; no other collaborators.
package insn_decoder_pkg;

  localparam int unsigned WORD_W = 14;

  // Register byte offsets on the APB window
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_WORD     = 12'h004;
  localparam logic [11:0] OFS_CONTEXT  = 12'h008;
  localparam logic [11:0] OFS_RESULT   = 12'h00c;
  localparam logic [11:0] OFS_PTRS     = 12'h010;

  // Field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTX_ZERO_BIT   = 0;
  localparam int unsigned CTX_BIT_BIT    = 1;
  localparam int unsigned PTR0_MSB_BIT   = 0;
  localparam int unsigned PTR1_MSB_BIT   = 1;
  localparam int unsigned RES_CLASS_LSB  = 0;
  localparam int unsigned RES_DEST_BIT   = 8;
  localparam int unsigned RES_FLAGS_LSB  = 12;
  localparam int unsigned RES_CYC_LSB    = 20;
  localparam int unsigned RES_COUNT_LSB  = 24;

  // Reset values
  localparam logic [13:0] WORD_RST = 14'h0000;
  localparam logic        EN_RST   = 1'b1;

  // Timing
  localparam int unsigned OSC_PER_CYCLE = 4;
  localparam logic [1:0]  CYC_ONE   = 2'h1;
  localparam logic [1:0]  CYC_TWO   = 2'h2;

  // Flag mask bits {pd, to, z, dc, c}
  localparam logic [4:0] FLG_NONE = 5'h00;
  localparam logic [4:0] FLG_C    = 5'h01;
  localparam logic [4:0] FLG_Z    = 5'h04;
  localparam logic [4:0] FLG_CDZ  = 5'h07;
  localparam logic [4:0] FLG_TOPD = 5'h18;

  // Fixed inherent words
  localparam logic [13:0] W_BRANCH_ACC = 14'h000b;
  localparam logic [13:0] W_CALL_ACC   = 14'h000a;
  localparam logic [13:0] W_INT_RET    = 14'h0009;
  localparam logic [13:0] W_WDT        = 14'h0064;
  localparam logic [13:0] W_OPTION     = 14'h0062;
  localparam logic [13:0] W_SWRESET    = 14'h0001;
  localparam logic [13:0] W_STANDBY    = 14'h0063;

  // Top six bits (top four for the bit tests)
  localparam logic [5:0] TOP_RRF  = 6'h0c;
  localparam logic [5:0] TOP_SUBB = 6'h3b;
  localparam logic [5:0] TOP_XOR  = 6'h06;
  localparam logic [5:0] TOP_DECS = 6'h0b;
  localparam logic [5:0] TOP_INCS = 6'h0f;
  localparam logic [5:0] TOP_IOR  = 6'h38;
  localparam logic [5:0] TOP_SUBL = 6'h3c;
  localparam logic [5:0] TOP_RETL = 6'h34;
  localparam logic [5:0] TOP_LIT1 = 6'h31;
  localparam logic [5:0] TOP_IDX  = 6'h3f;
  localparam logic [3:0] TOP_BTC  = 4'h6;
  localparam logic [3:0] TOP_BTS  = 4'h7;

  // Indirect data port addresses (file 0 and 1)
  localparam logic [6:0] ADDR_IND0 = 7'h00;
  localparam logic [6:0] ADDR_IND1 = 7'h01;

  typedef enum logic [4:0] {
    nop_op,
    rotate_right_carry_op,
    subtract_borrow_op,
    xor_acc_file_op,
    decrement_skip_zero_op,
    increment_skip_zero_op,
    bit_test_skip_clear_op,
    bit_test_skip_set_op,
    or_literal_op,
    load_page_latch_op,
    literal_minus_acc_op,
    branch_by_acc_op,
    call_by_acc_op,
    interrupt_return_op,
    return_literal_op,
    watchdog_restart_op,
    option_load_op,
    software_reset_op,
    standby_op,
    pointer_add_op,
    indirect_read_op
  } op_class_type;

endpackage

// *** verif/insn_decoder_test.sv ***
// Self-checking bench for the instruction decoder, driven over APB.
// Assumes the zero-wait APB slave and registered decode outputs of insn_decoder.
`timescale 1ns/1ps
`default_nettype none
module insn_decoder_test
  import insn_decoder_pkg::*;
();
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  op_class;
  logic        dest_file;
  logic [4:0]  flag_mask;
  logic [1:0]  cycles;
  logic        decode_valid;
  int          error_cnt;
  int          cmp_count;
  logic [7:0]  dec_count;

  // Opcode templates {pattern, operand mask}
  localparam logic [27:0] TPL [23] = '{
    {14'h0c00, 14'h00ff}, {14'h3b00, 14'h00ff}, {14'h0600, 14'h00ff},
    {14'h0b00, 14'h00ff}, {14'h0f00, 14'h00ff}, {14'h1800, 14'h03ff},
    {14'h1c00, 14'h03ff}, {14'h3800, 14'h00ff}, {14'h3180, 14'h007f},
    {14'h3c00, 14'h00ff}, {14'h000b, 14'h0000}, {14'h000a, 14'h0000},
    {14'h0009, 14'h0000}, {14'h3400, 14'h00ff}, {14'h0064, 14'h0000},
    {14'h0062, 14'h0000}, {14'h0001, 14'h0000}, {14'h0063, 14'h0000},
    {14'h3100, 14'h007f}, {14'h3f00, 14'h007f}, {14'h0000, 14'h0000},
    {14'h3e00, 14'h00ff}, {14'h1000, 14'h03fc}
  };

  insn_decoder DUT (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .op_class     (op_class),
    .dest_file    (dest_file),
    .flag_mask    (flag_mask),
    .cycles       (cycles),
    .decode_valid (decode_valid)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reference decode: {class, flag mask, cycle count}
  function automatic logic [11:0] expect_of(input logic [13:0] w, input logic [1:0] ctx,
                                            input logic [1:0] ptr);
    logic [4:0] c;
    logic [4:0] f;
    logic [1:0] y;
    logic       fo;
    c  = nop_op;
    f  = FLG_NONE;
    y  = CYC_ONE;
    fo = 1'b1;
    if (w[13:8] == TOP_RRF) begin c = rotate_right_carry_op; f = FLG_C; end
    else if (w[13:8] == TOP_SUBB) begin c = subtract_borrow_op; f = FLG_CDZ; end
    else if (w[13:8] == TOP_XOR) begin c = xor_acc_file_op; f = FLG_Z; end
    else if (w[13:8] == TOP_DECS) begin c = decrement_skip_zero_op; y = ctx[0] ? 2'h2 : 2'h1; end
    else if (w[13:8] == TOP_INCS) begin c = increment_skip_zero_op; y = ctx[0] ? 2'h2 : 2'h1; end
    else if (w[13:10] == TOP_BTC) begin c = bit_test_skip_clear_op; y = ctx[1] ? 2'h1 : 2'h2; end
    else if (w[13:10] == TOP_BTS) begin c = bit_test_skip_set_op; y = ctx[1] ? 2'h2 : 2'h1; end
    else
    begin
      fo = 1'b0;
      if (w[13:8] == TOP_IOR) begin c = or_literal_op; f = FLG_Z; end
      else if (w[13:7] == {TOP_LIT1, 1'b1}) c = load_page_latch_op;
      else if (w[13:8] == TOP_SUBL) begin c = literal_minus_acc_op; f = FLG_CDZ; end
      else if (w[13:8] == TOP_RETL) begin c = return_literal_op; y = CYC_TWO; end
      else if (w[13:7] == {TOP_LIT1, 1'b0}) c = pointer_add_op;
      else if (w[13:7] == {TOP_IDX, 1'b0})
      begin
        c = indirect_read_op;
        f = FLG_Z;
        y = ptr[w[6]] ? 2'h2 : 2'h1;
      end
      else if (w == W_BRANCH_ACC) begin c = branch_by_acc_op; y = CYC_TWO; end
      else if (w == W_CALL_ACC) begin c = call_by_acc_op; y = CYC_TWO; end
      else if (w == W_INT_RET) begin c = interrupt_return_op; y = CYC_TWO; end
      else if (w == W_WDT) begin c = watchdog_restart_op; f = FLG_TOPD; end
      else if (w == W_OPTION) c = option_load_op;
      else if (w == W_SWRESET) c = software_reset_op;
      else if (w == W_STANDBY) begin c = standby_op; f = FLG_TOPD; end
    end
    if (fo && w[6:1] == 6'h00 && ptr[w[0]])
      y = y + 2'h1;
    return {c, f, y};
  endfunction

  task automatic run_one(input logic [13:0] w, input logic [1:0] ctx, input logic [1:0] ptr);
    logic [11:0] e;
    logic [31:0] r;
    logic        er;
    int          n;
    e = expect_of(w, ctx, ptr);
    apb(1'b1, OFS_CONTEXT, {30'h0, ctx}, r, er);
    apb(1'b1, OFS_PTRS, {30'h0, ptr}, r, er);
    apb(1'b1, OFS_WORD, {18'h0, w}, r, er);
    n = 0;
    while (decode_valid !== 1'b1 && n < 8)
    begin
      @(posedge pclk);
      n++;
    end
    dec_count++;
    chk(n < 8, 1'b1);
    chk(op_class, e[11:7]);
    chk(flag_mask, e[6:2]);
    chk(cycles, e[1:0]);
    if (w[13:8] inside {TOP_RRF, TOP_SUBB, TOP_XOR, TOP_DECS, TOP_INCS})
      chk(dest_file, w[7]);
    else
      chk(dest_file, 1'b0);
    @(posedge pclk);
    chk(decode_valid, 1'b0);
    apb(1'b0, OFS_RESULT, 32'h0, r, er);
    chk({r[31:24], r[21:20], r[16:12], r[4:0]}, {dec_count, e[1:0], e[6:2], e[11:7]});
    chk(er, 1'b0);
  endtask

  initial
  begin
    #500000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    logic [31:0] r;
    logic        er;
    logic [13:0] w;
    int          k;
    int          n;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    dec_count = 8'h00;
    void'($urandom(32'hc7b12426));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({op_class, flag_mask, cycles, decode_valid}, {5'h00, 5'h00, CYC_ONE, 1'b0});
    apb(1'b0, OFS_CTRL, 32'h0, r, er);
    chk(r, {31'h0, EN_RST});
    apb(1'b0, OFS_WORD, 32'h0, r, er);
    chk(r, {18'h0, WORD_RST});
    $display("test reset values done");
    // Every template, skip and indirect both off and on
    for (k = 0; k < 46; k++)
    begin
      w = TPL[k / 2][27:14] | (14'($urandom) & TPL[k / 2][13:0]);
      if (TPL[k / 2][6])
        w[6:1] = 6'h00;
      run_one(w, (k % 2) ? 2'h3 : 2'h0, (k % 2) ? 2'h3 : 2'h0);
    end
    $display("test encoding table done");
    for (n = 0; n < 150; n++)
    begin
      k = $urandom % 23;
      w = TPL[k][27:14] | (14'($urandom) & TPL[k][13:0]);
      if ($urandom % 2 && TPL[k][6])
        w[6:1] = 6'h00;
      run_one(w, 2'($urandom), 2'($urandom));
    end
    $display("test random words done");
    // Disabled decoder must stay silent but keep the word
    apb(1'b1, OFS_CTRL, 32'h0, r, er);
    apb(1'b1, OFS_WORD, {18'h0, W_CALL_ACC}, r, er);
    n = 0;
    repeat (6)
    begin
      @(posedge pclk);
      if (decode_valid === 1'b1)
        n++;
    end
    chk(n, 0);
    apb(1'b0, OFS_WORD, 32'h0, r, er);
    chk(r, {18'h0, W_CALL_ACC});
    apb(1'b1, OFS_CTRL, 32'h1, r, er);
    run_one(W_STANDBY, 2'h0, 2'h0);
    $display("test disable done");
    apb(1'b0, 12'h014, 32'h0, r, er);
    chk({er, r}, {1'b1, 32'h0});
    apb(1'b1, 12'h020, 32'hffffffff, r, er);
    chk(er, 1'b1);
    $display("test unmapped done");
    end_of_test();
  end
endmodule
`default_nettype wire
